//--- src/lsg_gpio.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsg_consts.svh"
module lsg_gpio (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire lsg_pkg::lsg_apb_req_s i_apb,
  output lsg_pkg::lsg_apb_rsp_s o_apb,
  input wire lsg_pkg::lsg_line_t i_pin,
  output lsg_pkg::lsg_line_t o_pin,
  output lsg_pkg::lsg_line_t o_pin_oe,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset image of the state

  localparam lsg_pkg::lsg_state_s RST_STATE = '{
    dir: `LSG_RST_DIR,
    level: `LSG_RST_LEVEL,
    cfg: `LSG_RST_CFG,
    mask: `LSG_RST_MASK,
    pend: 1'b0,
    evst: 2'h0,
    evmsk: `LSG_RST_EVMSK,
    sync_a: '0,
    sync_b: '0,
    prev: '0,
    rsp: '0,
    pin_drv: '0,
    irq: 1'b0
  };

  lsg_pkg::lsg_state_s st;
  lsg_pkg::lsg_state_s next_st;
  logic apb_setup;
  logic apb_done;
  logic apb_wr;
  logic apb_rd;
  logic ext_lvl;
  logic ext_prv;
  logic ext_hit;
  logic ext_ev;
  logic dip_ev;

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode, shared by the read path and error reporting

  // Returns {error, data}; unmapped offsets answer zero with an error
  function automatic logic [32:0] read_word(input lsg_pkg::lsg_state_s s,
                                            input logic [`LSG_AW-1:0] addr);
    logic [32:0] r;
    r = {1'b0, 32'h00000000};
    unique case (addr)
      `LSG_OFF_DIR: r[31:0] = 32'(s.dir);
      // Inputs read the pin, outputs read back the stored level
      `LSG_OFF_LEVEL: r[31:0] = 32'((s.level & s.dir) | (s.sync_b & ~s.dir));
      `LSG_OFF_CFG: r[31:0] = 32'(s.cfg);
      `LSG_OFF_MASK: r[31:0] = 32'(s.mask);
      `LSG_OFF_PEND: r[31:0] = 32'(s.pend);
      `LSG_OFF_EVST: r[31:0] = 32'(s.evst);
      `LSG_OFF_EVMSK: r[31:0] = 32'(s.evmsk);
      default: r[32] = 1'b1;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase decode
  // Register map, one aligned word each:
  //   0x000 direction, one bit per line, one drives the line
  //   0x004 level; outputs read back the stored bit, inputs the pin
  //   0x008 interrupt configuration: enable, polarity, falling, rising
  //   0x00C interrupt mask: bit 0 masks line 8, bit 21 blocks all delivery but not pending
  //   0x010 pending: set by a line 8 event, write one to clear
  //   0x014 event status: sticky, cleared by the read that returns it
  //   0x018 event mask for the status bits
  // Other offsets answer zero with an error and ignore writes.
  // Level mode sets pending again every cycle while the line is active,
  // so software that clears it in level mode sees it return at once.
  // The answer is registered from the setup cycle, so read data is the
  // value of the registers at that edge, not at the completing edge.
  // Masters must not stretch the access phase; pready is a single pulse.

  // Answer is registered, so every access takes exactly one wait-free access cycle
  assign apb_setup = i_apb.psel & ~i_apb.penable;
  assign apb_done = i_apb.psel & i_apb.penable & st.rsp.pready;
  assign apb_wr = apb_done & i_apb.pwrite;
  assign apb_rd = apb_done & ~i_apb.pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // External interrupt detection on line 8

  // Polarity folds in first so edge modes work on the active sense
  assign ext_lvl = st.sync_b[`LSG_EXT_LINE] ~^ st.cfg[`LSG_CFG_POL];
  assign ext_prv = st.prev[`LSG_EXT_LINE] ~^ st.cfg[`LSG_CFG_POL];

  // Single-edge modes turn one switch pulse into one event; both-edge mode gives two
  always_comb
  begin
    unique case ({st.cfg[`LSG_CFG_FALL], st.cfg[`LSG_CFG_RISE]})
      2'b00: ext_hit = ext_lvl;
      2'b01: ext_hit = ext_lvl & ~ext_prv;
      2'b10: ext_hit = ~ext_lvl & ext_prv;
      2'b11: ext_hit = ext_lvl ^ ext_prv;
    endcase
  end

  assign ext_ev = st.cfg[`LSG_CFG_EN] & ext_hit;
  // Any change on a DIP line that is an input
  assign dip_ev = |((st.sync_b ^ st.prev) & `LSG_DIP_MASK & ~st.dir);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_st = st;
    // Two-stage synchroniser, then a history stage for edges
    next_st.sync_a = i_pin;
    next_st.sync_b = st.sync_a;
    next_st.prev = st.sync_b;
    // Register writes take effect at the completing edge only
    if (apb_wr)
    begin
      unique case (i_apb.paddr)
        `LSG_OFF_DIR: next_st.dir = i_apb.pwdata[`LSG_LINES-1:0];
        `LSG_OFF_LEVEL: next_st.level = i_apb.pwdata[`LSG_LINES-1:0];
        `LSG_OFF_CFG: next_st.cfg = i_apb.pwdata[4:0];
        `LSG_OFF_MASK: next_st.mask = i_apb.pwdata[21:0];
        `LSG_OFF_PEND: next_st.pend = st.pend & ~i_apb.pwdata[0];
        `LSG_OFF_EVMSK: next_st.evmsk = i_apb.pwdata[1:0];
        default: next_st.pend = st.pend;
      endcase
    end
    // Read clears only the bits that were returned, so a late event survives
    if (apb_rd && i_apb.paddr == `LSG_OFF_EVST)
      next_st.evst = st.evst & ~st.rsp.prdata[1:0];
    // Hardware sets win over any clear in the same cycle
    if (ext_ev)
      next_st.pend = 1'b1;
    next_st.evst[`LSG_EV_EXT] = next_st.evst[`LSG_EV_EXT] | ext_ev;
    next_st.evst[`LSG_EV_DIP] = next_st.evst[`LSG_EV_DIP] | dip_ev;
    // Answer is raised for exactly the first access cycle
    next_st.rsp.pready = apb_setup;
    if (apb_setup)
      {next_st.rsp.pslverr, next_st.rsp.prdata} = read_word(st, i_apb.paddr);
    else if (apb_done)
      next_st.rsp.pslverr = 1'b0;
    // Input lines never drive, whatever their level bit holds
    next_st.pin_drv = next_st.level & next_st.dir;
    // Global bit blocks delivery but not pending
    next_st.irq = ~next_st.mask[`LSG_MASK_GLOBAL] &
                  ((next_st.pend & ~next_st.mask[`LSG_MASK_EXT0]) |
                   (|(next_st.evst & next_st.evmsk)));
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Synchronous reset loads constants only
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      st <= RST_STATE;
    else
      st <= next_st;
  end

  // Outputs come straight from state flops
  assign o_apb = st.rsp;
  assign o_pin = st.pin_drv;
  assign o_pin_oe = st.dir;
  assign o_irq = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  a_oe_follow_dir: assert property (
    apb_wr && i_apb.paddr == `LSG_OFF_DIR |=> o_pin_oe == $past(i_apb.pwdata[17:0]))
    else $error("output enable does not follow direction write");

  a_led_level_drive: assert property (
    apb_wr && i_apb.paddr == `LSG_OFF_LEVEL |=>
      (o_pin & `LSG_LED_MASK) == ($past(i_apb.pwdata[17:0]) & o_pin_oe & `LSG_LED_MASK))
    else $error("LED lines do not follow level write");

  a_seg_drive: assert property (
    apb_wr && i_apb.paddr == `LSG_OFF_LEVEL ##1 !apb_wr[*2] |->
      (o_pin & `LSG_SEGMENT_FIELD_MASK) == (st.level & st.dir & `LSG_SEGMENT_FIELD_MASK))
    else $error("segment lines lost their level");

  a_seg_field: assert property (
    apb_wr && i_apb.paddr == `LSG_OFF_LEVEL && i_apb.pwdata[17:0] == `LSG_SEGMENT_FIELD_MASK &&
      (st.dir & `LSG_SEGMENT_FIELD_MASK) == `LSG_SEGMENT_FIELD_MASK && !(apb_wr && i_apb.paddr == `LSG_OFF_DIR)
      |=> o_pin[16:10] == 7'h7F && o_pin[9:0] == 10'h000)
    else $error("segment field misplaced");

  a_read_switch: assert property (
    apb_setup && !i_apb.pwrite && i_apb.paddr == `LSG_OFF_LEVEL && st.dir[3:0] == 4'h0
      |=> o_apb.pready && o_apb.prdata[3:0] == $past(st.sync_b[3:0]))
    else $error("switch read returns wrong value");

  a_cfg_reset: assert property (
    $past(!i_nrst) |-> st.cfg == 5'h00 && !o_irq)
    else $error("configuration not zero after reset");

  a_edge_sets_pend: assert property (
    st.cfg == 5'h19 && $rose(st.sync_b[8]) |=> st.pend)
    else $error("rising edge on line 8 missed");

  a_one_event_per_pulse: assert property (
    st.cfg == 5'h19 && ext_ev |=> !ext_ev)
    else $error("one pulse raised two events");

  a_mask_gate: assert property (
    st.pend && st.mask[0] && st.evst == 2'h0 |-> !o_irq)
    else $error("masked source delivered an interrupt");

  a_global_off: assert property (
    st.mask[21] |-> !o_irq)
    else $error("interrupt delivered while globally disabled");

  a_pend_w1c: assert property (
    apb_wr && i_apb.paddr == `LSG_OFF_PEND && i_apb.pwdata[0] && !ext_ev |=> !st.pend)
    else $error("pending bit not cleared by write of one");

  a_input_quiet: assert property (
    (o_pin & ~o_pin_oe) == 18'h00000)
    else $error("input line driven");

  // Register, interrupt and bus behaviour held cycle by cycle
  a_irq_unmasked: assert property (
    st.pend && !st.mask[0] && !st.mask[21] |-> o_irq)
    else $error("unmasked pending bit gave no interrupt");

  a_pend_hold: assert property (
    st.pend && !(apb_wr && i_apb.paddr == `LSG_OFF_PEND && i_apb.pwdata[0]) |=> st.pend)
    else $error("pending bit lost without a clear");

  a_pend_needs_event: assert property (
    !st.pend && !ext_ev |=> !st.pend)
    else $error("pending bit set without an event");

  a_disabled_no_event: assert property (
    !st.cfg[4] |-> !ext_ev)
    else $error("event raised while line 8 interrupt disabled");

  a_global_keeps_pend: assert property (
    st.mask[21] && ext_ev |=> st.pend)
    else $error("pending bit not set while globally disabled");

  a_ready_one_cycle: assert property (
    o_apb.pready |=> !o_apb.pready)
    else $error("ready held longer than one cycle");

  a_ready_after_setup: assert property (
    apb_setup |=> o_apb.pready)
    else $error("no ready after setup");

  a_dir_hold: assert property (
    !(apb_wr && i_apb.paddr == `LSG_OFF_DIR) |=> $stable(o_pin_oe))
    else $error("output enable changed without a write");

  a_level_hold: assert property (
    !(apb_wr && (i_apb.paddr == `LSG_OFF_LEVEL || i_apb.paddr == `LSG_OFF_DIR)) |=> $stable(o_pin))
    else $error("pin drive changed without a write");

  a_cfg_write: assert property (
    apb_wr && i_apb.paddr == `LSG_OFF_CFG |=> st.cfg == $past(i_apb.pwdata[4:0]))
    else $error("configuration write lost");

  a_cfg_hold: assert property (
    !(apb_wr && i_apb.paddr == `LSG_OFF_CFG) |=> $stable(st.cfg))
    else $error("configuration changed without a write");

  a_mask_write: assert property (
    apb_wr && i_apb.paddr == `LSG_OFF_MASK |=> st.mask == $past(i_apb.pwdata[21:0]))
    else $error("mask write lost");

  a_dir_read: assert property (
    apb_setup && !i_apb.pwrite && i_apb.paddr == `LSG_OFF_DIR |=>
      o_apb.prdata == 32'($past(st.dir)))
    else $error("direction read wrong");

  a_level_out_read: assert property (
    apb_setup && !i_apb.pwrite && i_apb.paddr == `LSG_OFF_LEVEL |=>
      (o_apb.prdata[17:0] & $past(st.dir)) == ($past(st.level) & $past(st.dir)))
    else $error("output line read does not return its level");

  a_unmapped_err: assert property (
    apb_setup && i_apb.paddr == 12'h01C |=> o_apb.pslverr && o_apb.prdata == 32'h00000000)
    else $error("unmapped offset answered without error");

  a_mapped_ok: assert property (
    apb_setup && i_apb.paddr == `LSG_OFF_LEVEL |=> !o_apb.pslverr)
    else $error("mapped offset answered with error");

  a_pin_off_reset: assert property (
    $past(!i_nrst) |-> o_pin == 18'h00000 && o_pin_oe == 18'h00000)
    else $error("lines not inputs after reset");

  a_mask_reset: assert property (
    $past(!i_nrst) |-> st.mask == 22'h3FFFFF)
    else $error("mask not fully set after reset");

  a_led_off: assert property (
    apb_wr && i_apb.paddr == `LSG_OFF_LEVEL && i_apb.pwdata[7:4] == 4'h0 |=> o_pin[7:4] == 4'h0)
    else $error("LED still lit after clear");

  a_seg_off: assert property (
    apb_wr && i_apb.paddr == `LSG_OFF_LEVEL && i_apb.pwdata[16:10] == 7'h00 |=>
      o_pin[16:10] == 7'h00)
    else $error("segment still lit after clear");

  a_dip_no_drive: assert property (
    st.dir[3:0] == 4'h0 |-> o_pin[3:0] == 4'h0)
    else $error("switch line driven");

  a_evst_sticky: assert property (
    st.evst[1] && !(apb_rd && i_apb.paddr == `LSG_OFF_EVST) |=> st.evst[1])
    else $error("event status lost without a read");

  c_ext_irq: cover property ($rose(o_irq) && st.pend);
  c_pend_clear: cover property (st.pend ##1 !st.pend);
  c_dip_read: cover property (apb_rd && i_apb.paddr == `LSG_OFF_LEVEL);
  c_unmapped: cover property (o_apb.pready && o_apb.pslverr);
  c_evt_irq: cover property (o_irq && st.evst != 2'h0 && !st.pend);

endmodule
`default_nettype wire

//--- src/lsg_consts.svh
`ifndef LSG_CONSTS_SVH
`define LSG_CONSTS_SVH
// Port geometry and bus address width
`define LSG_LINES 18
`define LSG_AW 12
// Register byte offsets
`define LSG_OFF_DIR 12'h000
`define LSG_OFF_LEVEL 12'h004
`define LSG_OFF_CFG 12'h008
`define LSG_OFF_MASK 12'h00C
`define LSG_OFF_PEND 12'h010
`define LSG_OFF_EVST 12'h014
`define LSG_OFF_EVMSK 12'h018
// Reset values
`define LSG_RST_DIR 18'h00000
`define LSG_RST_LEVEL 18'h00000
`define LSG_RST_CFG 5'h00
`define LSG_RST_MASK 22'h3FFFFF
`define LSG_RST_EVMSK 2'h0
// Line groups on the board
`define LSG_LED_MASK 18'h000F0
`define LSG_SEGMENT_FIELD_MASK 18'h1FC00
`define LSG_DIP_MASK 18'h0000F
`define LSG_EXT_LINE 8
// Field positions
`define LSG_CFG_EN 4
`define LSG_CFG_POL 3
`define LSG_CFG_FALL 1
`define LSG_CFG_RISE 0
`define LSG_MASK_EXT0 0
`define LSG_MASK_GLOBAL 21
`define LSG_EV_EXT 0
`define LSG_EV_DIP 1
`endif

//--- src/lsg_pkg.sv
`include "lsg_consts.svh"
package lsg_pkg;
  typedef logic [`LSG_LINES-1:0] lsg_line_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`LSG_AW-1:0] paddr;
    logic [31:0] pwdata;
  } lsg_apb_req_s;

  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lsg_apb_rsp_s;

  // Whole state of the port
  typedef struct packed {
    lsg_line_t dir;
    lsg_line_t level;
    logic [4:0] cfg;
    logic [21:0] mask;
    logic pend;
    logic [1:0] evst;
    logic [1:0] evmsk;
    lsg_line_t sync_a;
    lsg_line_t sync_b;
    lsg_line_t prev;
    lsg_apb_rsp_s rsp;
    lsg_line_t pin_drv;
    logic irq;
  } lsg_state_s;
endpackage

//--- test/lsg_board_model.sv
`timescale 1ns/1ps
`default_nettype none
// Board side of the port: LEDs, segments, DIP switch and push switch
module lsg_board_model (
  input wire logic i_clk,
  input wire lsg_pkg::lsg_line_t i_drive,
  input wire lsg_pkg::lsg_line_t i_oe,
  input wire logic [3:0] i_dip,
  input wire logic i_push,
  output lsg_pkg::lsg_line_t o_level,
  output logic [3:0] o_leds,
  output logic [6:0] o_segs
);
  lsg_pkg::lsg_line_t float_q = 18'h15555;
  lsg_pkg::lsg_line_t board;
  // Unused lines float, so they change every cycle rather than hold a value
  always @(posedge i_clk) float_q <= ~float_q;
  // Switch ON pulls high, push switch gives one pulse per press
  always_comb
  begin
    board = float_q;
    board[3:0] = i_dip;
    board[8] = i_push;
    o_level = (i_oe & i_drive) | (~i_oe & board);
  end
  assign o_leds = o_level[7:4] & i_oe[7:4];
  assign o_segs = o_level[16:10] & i_oe[16:10];
endmodule
`default_nettype wire

//--- test/tb_led_switch_gpio_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_led_switch_gpio_port;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  lsg_pkg::lsg_apb_req_s req = '0;
  lsg_pkg::lsg_apb_rsp_s rsp;
  lsg_pkg::lsg_line_t pin, drv, oe;
  logic [3:0] dip = 4'h0;
  logic push = 1'b0;
  logic [3:0] leds;
  logic [6:0] segs;
  logic [31:0] r;
  logic e;
  logic irq;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  always #4 i_clk = ~i_clk;
  lsg_gpio dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_apb(req), .o_apb(rsp), .i_pin(pin),
    .o_pin(drv), .o_pin_oe(oe), .o_irq(irq));
  lsg_board_model board_u (.i_clk(i_clk), .i_drive(drv), .i_oe(oe), .i_dip(dip),
    .i_push(push), .o_level(pin), .o_leds(leds), .o_segs(segs));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for pready, bounded by the cycle ceiling
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clk);
    req.penable <= 1'b1;
    // Look at the answer between edges, where it is settled, then pass the edge
    do @(negedge i_clk); while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    @(posedge i_clk);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // Let registered outputs land before looking at them
  task automatic settle();
    @(posedge i_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(0, `LSG_OFF_DIR, 0); chk(r, 0);
    apb(0, `LSG_OFF_CFG, 0); chk(r, 0);
    apb(0, `LSG_OFF_MASK, 0); chk(r, 32'h003FFFFF);
    apb(0, 12'h01C, 0); chk(e, 1);
    $display("test reset done");
  endtask
  task automatic t_out();
    apb(1, `LSG_OFF_DIR, 32'h0001FCF0);
    apb(1, `LSG_OFF_LEVEL, 32'h0003FFFF);
    settle();
    chk(oe, 18'h1FCF0);
    chk(drv, 18'h1FCF0);
    chk({leds, segs}, 11'h7FF);
    // Read-modify-write that keeps the LEDs and lights only the top segment
    apb(0, `LSG_OFF_LEVEL, 0);
    apb(1, `LSG_OFF_LEVEL, (r & ~32'h0001FC00) | 32'h00000400);
    settle();
    chk({leds, segs}, 11'h781);
    $display("test outputs done");
  endtask
  task automatic t_dip();
    dip <= 4'hA;
    repeat (4) @(posedge i_clk);
    apb(0, `LSG_OFF_LEVEL, 0);
    chk(r & 32'hF, 32'hA);
    $display("test dip done");
  endtask
  task automatic t_irq();
    apb(1, `LSG_OFF_CFG, 32'h19);
    apb(1, `LSG_OFF_MASK, 32'h00200000);
    push <= 1'b1;
    repeat (4) @(posedge i_clk);
    push <= 1'b0;
    r = 0;
    for (int i = 0; i < 20 && r[0] !== 1'b1; i++) apb(0, `LSG_OFF_PEND, 0);
    chk(r & 1, 1);
    settle();
    chk(irq, 0);
    apb(1, `LSG_OFF_MASK, 0);
    settle();
    chk(irq, 1);
    apb(1, `LSG_OFF_PEND, 1);
    settle();
    chk(irq, 0);
    apb(0, `LSG_OFF_CFG, 0); chk(r, 32'h19);
    $display("test interrupt done");
  endtask
  task automatic t_evt();
    // Line 8 event and the earlier switch change are both still recorded
    apb(0, `LSG_OFF_EVST, 0); chk(r, 3);
    apb(1, `LSG_OFF_EVMSK, 2);
    dip <= 4'h5;
    repeat (6) @(posedge i_clk);
    #1;
    chk(irq, 1);
    apb(0, `LSG_OFF_EVST, 0); chk(r, 2);
    settle();
    chk(irq, 0);
    $display("test event done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_out();
    t_dip();
    t_irq();
    t_evt();
    tally_and_finish();
  end
endmodule
`default_nettype wire
